// file: include/ilo_pkg.sv
package ilo_pkg;
  // ---------------------------------------------------------------
  // opcode encodings
  // ---------------------------------------------------------------
  localparam logic [15:0] MOVE_FIRST_MASK  = 16'hFF80;
  localparam logic [15:0] MOVE_FIRST_MATCH = 16'hEB80;
  localparam logic [3:0]  MOVE_SECOND_TOP  = 4'hF;
  localparam logic [7:0]  PUSH_TOP         = 8'hFA;
  // ---------------------------------------------------------------
  // address layout
  // ---------------------------------------------------------------
  localparam int          ADDR_W           = 12;
  localparam logic [7:0]  OFFSET_LIMIT     = 8'h5F;
  localparam logic [11:0] ACCESS_HIGH_BASE = 12'hF00;
  // indirect data registers live in the special function area
  localparam logic [11:0] INDIRECT_FIRST   = 12'hFDB;
  localparam logic [11:0] INDIRECT_LAST    = 12'hFEF;
  localparam logic [7:0]  ZERO_BYTE        = 8'h00;
  localparam logic [11:0] FP_RESET         = 12'h000;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SECOND = 2'b01,
    ST_WRITE  = 2'b10
  } state_t;
endpackage

// file: rtl/indexed_offset_addressing.sv
`timescale 1ns/100ps
// Behaviour
// - move addresses are frame pointer plus offsets
// - both move addresses span full 12-bit space
// - indirect source register reads as zero
// - indirect destination turns move into no-op
// - push writes literal then decrements frame pointer
// - extension off uses file address literally
// - extension on also enables offset mode
// - access flag zero, operand <=5Fh: frame offset
// - operands above 5Fh keep direct meaning
// - offset mode covers all access-flag instructions
// - zero frame pointer gives original access map
// - destination flag keeps its normal meaning
module indexed_offset_addressing (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ext_enable,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr,
  input  wire logic        std_access,
  input  wire logic        std_a,
  input  wire logic        std_d,
  input  wire logic [7:0]  std_f,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic [7:0]  rd_data,
  output logic [11:0]      mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [7:0]       wr_data,
  output logic [11:0]      std_addr,
  output logic             std_to_file,
  output logic [11:0]      frame_pointer,
  output logic             busy,
  output logic             status_we
);

  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    ilo_pkg::state_t state;
    logic [11:0]     dst;
    logic [11:0]     addr;
    logic            rd;
    logic            wr;
    logic [7:0]      data;
    logic [11:0]     saddr;
    logic            sfile;
    logic [11:0]     fp;
    logic            bsy;
    logic            swe;
  } regs_t;

  regs_t r;
  regs_t next_r;

  // ---------------------------------------------------------------
  // address helpers
  // ---------------------------------------------------------------
  // indirect data registers must never see a move access
  function automatic logic is_indirect(input logic [11:0] a);
    is_indirect = (a >= ilo_pkg::INDIRECT_FIRST) &&
                  (a <= ilo_pkg::INDIRECT_LAST);
  endfunction

  // offsets are unsigned; sums wrap inside the 4096-byte space
  logic [11:0] offset_word;
  logic [11:0] src_calc;
  logic [11:0] dst_calc;

  assign offset_word = {5'h00, instr[6:0]};
  assign src_calc    = r.fp + offset_word;
  assign dst_calc    = r.fp + offset_word;

  // ---------------------------------------------------------------
  // instruction decode
  // ---------------------------------------------------------------
  logic word_take;
  logic is_move_first;
  logic is_push;
  logic is_move_second;
  logic src_indirect;
  logic held_src_indirect;
  logic dst_indirect;

  // extended opcodes exist only while the extension is on
  assign word_take         = instr_valid && ext_enable;
  assign is_move_first     = (instr & ilo_pkg::MOVE_FIRST_MASK) ==
                             ilo_pkg::MOVE_FIRST_MATCH;
  assign is_push           = instr[15:8] == ilo_pkg::PUSH_TOP;
  assign is_move_second    = instr[15:12] == ilo_pkg::MOVE_SECOND_TOP;
  assign src_indirect      = is_indirect(src_calc);
  assign held_src_indirect = is_indirect(r.addr);
  assign dst_indirect      = is_indirect(r.dst);

  // ---------------------------------------------------------------
  // standard operand map
  // ---------------------------------------------------------------
  logic        low_operand;
  logic [11:0] bank_calc;
  logic [11:0] high_calc;
  logic [11:0] offset_calc;
  logic [11:0] direct_calc;
  logic [11:0] std_calc;

  assign low_operand = std_f <= ilo_pkg::OFFSET_LIMIT;
  assign bank_calc   = {bank_select_register, std_f};
  assign high_calc   = ilo_pkg::ACCESS_HIGH_BASE | {4'h0, std_f};
  // a zero frame pointer lands on the plain access bank
  assign offset_calc = r.fp + {4'h0, std_f};
  assign direct_calc = {4'h0, std_f};

  // access flag one wins before any offset decision
  assign std_calc = std_a        ? bank_calc   :
                    !low_operand ? high_calc   :
                    ext_enable   ? offset_calc :
                                   direct_calc;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r     = r;
    next_r.rd  = 1'b0;
    next_r.wr  = 1'b0;
    // move and push leave every status flag alone
    next_r.swe = 1'b0;

    if (std_access) begin
      next_r.saddr = std_calc;
      next_r.sfile = std_d;
    end

    unique case (r.state)
      ilo_pkg::ST_IDLE: begin
        next_r.bsy = 1'b0;
        if (word_take && is_move_first) begin
          // source read in first cycle
          next_r.addr  = src_calc;
          next_r.rd    = !src_indirect;
          next_r.state = ilo_pkg::ST_SECOND;
          next_r.bsy   = 1'b1;
        end else if (word_take && is_push) begin
          next_r.addr = r.fp;
          next_r.data = instr[7:0];
          next_r.wr   = 1'b1;
          next_r.fp   = r.fp - 12'h001;
        end
      end

      ilo_pkg::ST_SECOND: begin
        // second word carries the destination offset
        if (instr_valid && is_move_second) begin
          next_r.dst   = dst_calc;
          next_r.state = ilo_pkg::ST_WRITE;
        end
      end

      ilo_pkg::ST_WRITE: begin
        // indirect source yields zero rather than an indirect access
        next_r.data  = held_src_indirect ? ilo_pkg::ZERO_BYTE
                                         : rd_data;
        next_r.addr  = r.dst;
        next_r.wr    = !dst_indirect;
        next_r.state = ilo_pkg::ST_IDLE;
        next_r.bsy   = 1'b0;
      end

      default: begin
        next_r.state = ilo_pkg::ST_IDLE;
        next_r.bsy   = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r       <= '0;
      r.state <= ilo_pkg::ST_IDLE;
      r.fp    <= ilo_pkg::FP_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign mem_addr      = r.addr;
  assign mem_rd        = r.rd;
  assign mem_wr        = r.wr;
  assign wr_data       = r.data;
  assign std_addr      = r.saddr;
  assign std_to_file   = r.sfile;
  assign frame_pointer = r.fp;
  assign busy          = r.bsy;
  // held low in a flop so the port stays register-driven
  assign status_we     = r.swe;

endmodule // indexed_offset_addressing

// file: tb/indexed_offset_addressing_properties.sv
`timescale 1ns/100ps
module indexed_offset_addressing_properties (
  input wire logic        clk, rst_n, ext_enable, instr_valid, std_access,
  input wire logic        std_a, busy, status_we, mem_rd, mem_wr,
  input wire logic [15:0] instr,
  input wire logic [7:0]  std_f, wr_data,
  input wire logic [3:0]  bank_select_register,
  input wire logic [11:0] mem_addr, std_addr, frame_pointer
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // word 2 of a move also has a top nibble of F, so busy gates it out
  sequence take_push;
    instr_valid && ext_enable && !busy && instr[15:8] == 8'hFA;
  endsequence
  sequence take_move;
    instr_valid && ext_enable && !busy && instr[15:7] == 9'h1D7;
  endsequence
  AST_PUSH_WRITE: assert property (take_push |=> mem_wr &&
    mem_addr == $past(frame_pointer) && wr_data == $past(instr[7:0]))
    else $error("push write wrong");
  AST_PUSH_FP: assert property (take_push |=>
    frame_pointer == $past(frame_pointer) - 12'h001) else $error("push fp");
  sequence take_dest;
    instr_valid && instr[15:12] == 4'hF;
  endsequence
  AST_MOVE_SRC: assert property (take_move |=> busy &&
    mem_addr == $past(frame_pointer) + $past(instr[6:0]) &&
    mem_rd == !(mem_addr >= 12'hFDB && mem_addr <= 12'hFEF))
    else $error("move source wrong");
  AST_MOVE_WRITE: assert property (take_move ##1 take_dest |=> ##1
    !busy && mem_addr == $past(frame_pointer, 2) + $past(instr[6:0], 2) &&
    mem_wr == !(mem_addr >= 12'hFDB && mem_addr <= 12'hFEF))
    else $error("move write wrong");
  AST_NO_STATUS: assert property (status_we == 1'h0)
    else $error("status written");
  AST_STD_BANK: assert property (std_access && std_a |=>
    std_addr == {$past(bank_select_register), $past(std_f)})
    else $error("bank map wrong");
  AST_STD_OFFSET: assert property (std_access && !std_a && ext_enable &&
    std_f <= 8'h5F |=> std_addr == $past(frame_pointer) + $past(std_f))
    else $error("offset map wrong");
  AST_STD_HIGH: assert property (std_access && !std_a && std_f > 8'h5F
    |=> std_addr == {4'hF, $past(std_f)}) else $error("high map wrong");
  AST_STD_DIRECT: assert property (std_access && !std_a && !ext_enable &&
    std_f <= 8'h5F |=> std_addr == {4'h0, $past(std_f)})
    else $error("direct map wrong");
endmodule // indexed_offset_addressing_properties
bind indexed_offset_addressing indexed_offset_addressing_properties u_p (.*);

// file: tb/indexed_offset_addressing_tb.sv
`timescale 1ns/100ps
module indexed_offset_addressing_tb;
  logic        clk = 0, rst_n = 0, ext_enable = 1, instr_valid = 0;
  logic        std_access = 0, std_a = 0, std_d = 0;
  logic        mem_rd, mem_wr, std_to_file, busy, status_we;
  logic [15:0] instr = 16'h0000;
  logic [7:0]  std_f = 8'h00, rd_data = 8'h00, k, wr_data;
  logic [3:0]  bank_select_register = 4'h0;
  logic [11:0] mem_addr, std_addr, frame_pointer, fp;
  int          miscompares = 0, checks_done = 0;
  indexed_offset_addressing u_indexed_offset_addressing (.*);
  initial forever #50 clk = ~clk;
  task automatic chk(string n, logic [11:0] s, logic [11:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [11:0] map(logic [7:0] f, logic [11:0] p);
    if (std_a) return {bank_select_register, f};
    if (f <= 8'h5F) return ext_enable ? p + f : {4'h0, f};
    return {4'hF, f};
  endfunction
  task automatic push(logic [7:0] v);
    instr = {8'hFA, v};
    instr_valid = 1;
    fp = frame_pointer;
    @(negedge clk);
    chk("push_wr", mem_wr, 1'h1);
    chk("push_addr", mem_addr, fp);
    chk("push_data", wr_data, v);
    chk("push_fp", frame_pointer, fp - 12'h001);
  endtask
  function automatic logic ind(logic [11:0] a);
    return a >= 12'hFDB && a <= 12'hFEF;
  endfunction
  // read data is inverted outside its slot so a stale capture shows up;
  // callers keep destinations off the counter and stack top bytes
  task automatic move(logic [6:0] zs, zd, logic [7:0] ed, logic we);
    fp = frame_pointer;
    instr = {9'h1D7, zs};
    instr_valid = 1;
    rd_data = ~k;
    @(negedge clk);
    chk("move_src", mem_addr, fp + zs);
    chk("move_rd", mem_rd, !ind(fp + zs));
    chk("move_busy", busy, 1'h1);
    instr = {9'h1E0, zd};
    @(negedge clk);
    instr_valid = 0;
    rd_data = k;
    @(negedge clk);
    chk("move_wr", mem_wr, we);
    chk("move_idle", busy, 1'h0);
    if (we) chk("move_dst", mem_addr, fp + zd);
    if (we) chk("move_data", wr_data, ed);
    rd_data = ~k;
  endtask
  initial begin
    void'($urandom(30181));
    repeat (12) @(negedge clk);
    rst_n = 1;
    for (int i = 0; i < 128; i++) push(8'($urandom));
    instr_valid = 0;
    @(negedge clk);
    $display("push test done");
    k = 8'($urandom);
    move(7'h05, 7'h06, k, 1);
    move(7'h7F, 7'h00, k, 1);
    move(7'h5B, 7'h02, 8'h00, 1);
    move(7'h01, 7'h6F, k, 0);
    $display("move test done");
    rst_n = 0;
    @(negedge clk) rst_n = 1;
    chk("reset_fp", frame_pointer, 12'h000);
    std_access = 1;
    for (int i = 0; i < 300; i++) begin
      {ext_enable, std_a, std_d, std_f, bank_select_register} = 15'($urandom);
      @(negedge clk);
      chk("std_addr", std_addr, map(std_f, frame_pointer));
      chk("std_dest", std_to_file, std_d);
      if (i % 60 == 59) begin
        ext_enable = 1;
        push(8'($urandom));
        instr_valid = 0;
      end
    end
    $display("map test done");
    end_sim();
  end
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
endmodule // indexed_offset_addressing_tb
